// ===== wd_sleep_cfg.svh
/*
 * Constants for the watchdog and sleep controller: register offsets,
 * reset values, bus answers and timing counts.
 * Assumes inclusion by bare name from the design file and the bench.
 */
`ifndef WD_SLEEP_CFG_SVH
`define WD_SLEEP_CFG_SVH

// ----------------------------------------------------------------------
// Register map (indices; byte address is four times the index)
// ----------------------------------------------------------------------
`define OPTION_INDEX 12'h081
`define STATUS_INDEX 12'h003
`define OPTION_RESET 8'hFF

// ----------------------------------------------------------------------
// AXI4-Lite answers
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Start-up delay after wake in crystal modes, in main oscillator periods
`define OST_TOSC 1024
`define TOSC_NS 8
`define MCLK_NS 8
`define OST_CYCLES ((`OST_TOSC * `TOSC_NS + `MCLK_NS - 1) / `MCLK_NS)
// Watchdog base period in watchdog oscillator ticks, before postscaling
`define WD_BASE_TICKS 256

`endif

// ===== wd_sleep_pkg.sv
/*
 * Types shared by the watchdog and sleep controller.
 * Assumes nothing of its surroundings.
 */
package wd_sleep_pkg;

    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STARTUP} power_state_e;

    typedef struct packed {
        logic pullup_off;
        logic int_edge;
        logic t0_clock_src;
        logic t0_src_edge;
        logic prescaler_assign;
        logic prescale_select_hi;
        logic prescale_select_mid;
        logic prescale_select_lo;
    } option_s;

    typedef struct packed {
        logic [2:0] unused;
        logic timeout_flag_n;
        logic powerdown_flag_n;
        logic wake_pending;
        logic fuse_on;
        logic sleeping;
    } status_s;

    typedef logic [1:0] axi_resp_t;

endpackage

// ===== wd_sleep_ctrl.sv
/*
 * Watchdog and power-down controller with an AXI4-Lite register slave.
 * Assumes: CPU instruction strobes and interrupt flags come from logic on
 * mclk_in; the watchdog oscillator and master clear arrive as raw pins.
 */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wd_sleep_cfg.svh"

module wd_sleep_ctrl
    import wd_sleep_pkg::*;
#(
    parameter int IRQ_COUNT = 8,
    parameter logic [IRQ_COUNT-1:0] WAKE_CAPABLE = {IRQ_COUNT{1'b1}},
    parameter int PIN_COUNT = 8,
    parameter int ADDR_W = 12,
    parameter int BASE_TICKS = `WD_BASE_TICKS,
    parameter int OST_CYCLES = `OST_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // CPU instruction events
    input wire logic clear_watchdog_instr_in,
    input wire logic sleep_instr_in,
    input wire logic global_irq_enable_in,
    // Interrupt sources
    input wire logic [IRQ_COUNT-1:0] irq_flags_in,
    input wire logic [IRQ_COUNT-1:0] irq_enables_in,
    // Pins and fuses
    input wire logic master_clear_pin_n_in,
    input wire logic watchdog_osc_in,
    input wire logic watchdog_enable_fuse_in,
    input wire logic crystal_mode_in,
    // Port drive from the core
    input wire logic [PIN_COUNT-1:0] port_drive_in,
    input wire logic [PIN_COUNT-1:0] port_oe_in,
    // Outputs to the core and pads
    output logic device_reset_out,
    output logic osc_driver_off_out,
    output logic prefetch_next_out,
    output logic resume_out,
    output logic vector_after_next_out,
    output logic timeout_flag_n_out,
    output logic powerdown_flag_n_out,
    output logic [PIN_COUNT-1:0] port_drive_out,
    output logic [PIN_COUNT-1:0] port_oe_out
);

    localparam int BASE_W = (BASE_TICKS > 1) ? $clog2(BASE_TICKS) : 1;
    localparam int OST_W = $clog2(OST_CYCLES + 1);
    localparam logic [ADDR_W-1:0] OPTION_ADDR = ADDR_W'(`OPTION_INDEX * 4);
    localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'(`STATUS_INDEX * 4);

    // ------------------------------------------------------------------
    // Pin synchronisers and fuse capture
    // ------------------------------------------------------------------
    logic master_clear_pin_s1_q, master_clear_pin_s2_q;
    logic osc_s1_q, osc_s2_q, osc_s3_q;
    logic fuse_on_q, fuse_taken_q;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            master_clear_pin_s1_q <= 1'b1;
            master_clear_pin_s2_q <= 1'b1;
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            master_clear_pin_s1_q <= master_clear_pin_n_in;
            master_clear_pin_s2_q <= master_clear_pin_s1_q;
            osc_s1_q <= watchdog_osc_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            fuse_on_q <= 1'b0;
            fuse_taken_q <= 1'b0;
        end else if (!fuse_taken_q) begin
            fuse_on_q <= watchdog_enable_fuse_in;
            fuse_taken_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Decoded events
    // ------------------------------------------------------------------
    power_state_e state_q, state_d;
    option_s option_q;
    logic [BASE_W-1:0] base_q;
    logic [6:0] post_q, post_mask;
    logic [OST_W-1:0] ost_q;
    logic timeout_n_q, powerdown_n_q;
    logic master_clear_pin_active, wd_tick, wd_run, wake_pending;
    logic sleep_take, sleep_exec, sleep_nop, wd_clear, base_wrap, expire;
    logic wr_fire;

    assign master_clear_pin_active = ~master_clear_pin_s2_q;
    assign wd_tick = osc_s2_q & ~osc_s3_q;
    assign wd_run = fuse_on_q & fuse_taken_q;
    assign wake_pending = |(irq_flags_in & irq_enables_in & WAKE_CAPABLE);
    assign sleep_take = (state_q == ST_RUN) && sleep_instr_in && !master_clear_pin_active;
    // pending interrupt turns sleep into nop
    assign sleep_exec = sleep_take && !wake_pending;
    assign sleep_nop = sleep_take && wake_pending;
    assign wd_clear = (clear_watchdog_instr_in && state_q == ST_RUN) || sleep_exec ||
                      master_clear_pin_active;

    // ------------------------------------------------------------------
    // Watchdog counter and postscaler
    // ------------------------------------------------------------------
    // ratio 2^select when assigned, else 1:1
    assign post_mask = option_q.prescaler_assign ?
        7'((8'h01 << {option_q.prescale_select_hi, option_q.prescale_select_mid,
                      option_q.prescale_select_lo}) - 8'h01) : 7'h00;
    assign base_wrap = wd_tick && (base_q == BASE_W'(BASE_TICKS - 1));
    assign expire = wd_run && !wd_clear && base_wrap && ((post_q & post_mask) == post_mask);

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            base_q <= '0;
            post_q <= 7'h00;
        end else if (wd_clear || !wd_run || expire) begin
            base_q <= '0;
            post_q <= 7'h00;
        end else if (wd_tick) begin
            base_q <= base_wrap ? '0 : base_q + 1'b1;
            if (base_wrap) begin
                post_q <= post_q + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            timeout_n_q <= 1'b1;
            powerdown_n_q <= 1'b1;
        end else if (expire) begin
            timeout_n_q <= 1'b0;
        end else if (sleep_exec) begin
            timeout_n_q <= 1'b1;
            powerdown_n_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (sleep_exec) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (master_clear_pin_active) begin
                    state_d = ST_RUN;
                end else if (expire || wake_pending) begin
                    state_d = crystal_mode_in ? ST_STARTUP : ST_RUN;
                end
            end
            ST_STARTUP: begin
                if (master_clear_pin_active || ost_q == OST_W'(OST_CYCLES - 1)) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ost_q <= '0;
        end else if (state_q == ST_STARTUP) begin
            ost_q <= ost_q + 1'b1;
        end else begin
            ost_q <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            device_reset_out <= 1'b0;
            osc_driver_off_out <= 1'b0;
            prefetch_next_out <= 1'b0;
            resume_out <= 1'b0;
            vector_after_next_out <= 1'b0;
        end else begin
            // run-time expiry resets; master clear resets
            device_reset_out <= master_clear_pin_active || (expire && state_q != ST_SLEEP);
            osc_driver_off_out <= (state_d == ST_SLEEP);
            prefetch_next_out <= sleep_take;
            resume_out <= (state_q != ST_RUN) && (state_d == ST_RUN) && !master_clear_pin_active;
            vector_after_next_out <= (state_q != ST_RUN) && (state_d == ST_RUN) &&
                                     !master_clear_pin_active && global_irq_enable_in && wake_pending;
        end
    end

    assign timeout_flag_n_out = timeout_n_q;
    assign powerdown_flag_n_out = powerdown_n_q;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            port_drive_out <= '0;
            port_oe_out <= '0;
        end else if (state_d != ST_SLEEP) begin
            port_drive_out <= port_drive_in;
            port_oe_out <= port_oe_in;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_have_q, w_have_q;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_out;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_addr_q <= s_axi_awaddr_in;
                aw_have_q <= 1'b1;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_data_q <= s_axi_wdata_in;
                w_strb_q <= s_axi_wstrb_in;
                w_have_q <= 1'b1;
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                if (aw_addr_q[ADDR_W-1:2] == OPTION_ADDR[ADDR_W-1:2] ||
                    aw_addr_q[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2]) begin
                    s_axi_bresp_out <= `RESP_OKAY;
                end else begin
                    s_axi_bresp_out <= `RESP_SLVERR;
                end
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    // only bus writes touch the assignment bit
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            option_q <= `OPTION_RESET;
        end else if (wr_fire && w_strb_q[0] &&
                     aw_addr_q[ADDR_W-1:2] == OPTION_ADDR[ADDR_W-1:2]) begin
            option_q <= w_data_q[7:0];
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    status_s status;

    always_comb begin
        status = '0;
        status.timeout_flag_n = timeout_n_q;
        status.powerdown_flag_n = powerdown_n_q;
        status.wake_pending = wake_pending;
        status.fuse_on = wd_run;
        status.sleeping = (state_q != ST_RUN);
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= `RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            if (s_axi_araddr_in[ADDR_W-1:2] == OPTION_ADDR[ADDR_W-1:2]) begin
                s_axi_rdata_out <= {24'h00_0000, option_q};
                s_axi_rresp_out <= `RESP_OKAY;
            end else if (s_axi_araddr_in[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2]) begin
                s_axi_rdata_out <= {24'h00_0000, status};
                s_axi_rresp_out <= `RESP_OKAY;
            end else begin
                s_axi_rdata_out <= 32'h0000_0000;
                s_axi_rresp_out <= `RESP_SLVERR;
            end
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    chk_sleep_entry: assert property (
        sleep_exec |=> state_q == ST_SLEEP && !powerdown_n_q && timeout_n_q &&
                       osc_driver_off_out)
        else $error("sleep entry effects missing");
    chk_sleep_nop: assert property (
        sleep_nop |=> state_q == ST_RUN && powerdown_n_q == $past(powerdown_n_q))
        else $error("sleep with pending interrupt did not act as nop");
    chk_expiry_flag: assert property (
        expire |=> !timeout_n_q)
        else $error("expiry left timeout flag set");
    chk_run_reset: assert property (
        expire && state_q == ST_RUN |=> device_reset_out)
        else $error("run-time expiry gave no reset");
    chk_sleep_wake: assert property (
        expire && state_q == ST_SLEEP && !master_clear_pin_active |=> state_q != ST_SLEEP ##0
        !device_reset_out)
        else $error("expiry during sleep did not wake cleanly");
    chk_irq_wake: assert property (
        state_q == ST_SLEEP && wake_pending && !master_clear_pin_active |=> state_q != ST_SLEEP)
        else $error("enabled interrupt did not wake");
    chk_rc_no_delay: assert property (
        state_q == ST_SLEEP && wake_pending && !crystal_mode_in && !master_clear_pin_active |=>
        state_q == ST_RUN && resume_out)
        else $error("RC mode wake was delayed");
    chk_startup_bound: assert property (
        state_q == ST_STARTUP |-> ost_q < OST_W'(OST_CYCLES))
        else $error("start-up delay overran");
    chk_port_hold: assert property (
        state_q == ST_SLEEP ##1 state_q == ST_SLEEP |->
        $stable(port_drive_out) && $stable(port_oe_out))
        else $error("pin state changed during sleep");
    chk_wd_cleared: assert property (
        wd_clear |=> base_q == '0 && post_q == 7'h00)
        else $error("watchdog not cleared");
    chk_option_kept: assert property (
        clear_watchdog_instr_in && !wr_fire |=> $stable(option_q))
        else $error("clear-watchdog altered option register");
    chk_prefetch_pulse: assert property (
        sleep_take |=> prefetch_next_out)
        else $error("no prefetch on sleep");
    chk_master_clear: assert property (
        master_clear_pin_active |=> device_reset_out && !resume_out)
        else $error("master clear gave no reset");
    chk_fuse_off: assert property (
        fuse_taken_q && !fuse_on_q |-> !expire && base_q == '0)
        else $error("disabled watchdog still counting");

endmodule

`default_nettype wire

// ===== cpu_core_model.sv
/* CPU core model: turns bench commands into instruction strobes.
   Assumes it shares mclk_in and reset_in with the controller. */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // Bench commands
    input wire logic sleep_cmd_in,
    input wire logic clear_cmd_in,
    // Instruction strobes
    output logic clear_watchdog_instr_out,
    output logic sleep_instr_out
);
    logic sleep_q;
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sleep_q <= 1'b0;
            sleep_instr_out <= 1'b0;
            clear_watchdog_instr_out <= 1'b0;
        end else begin
            sleep_q <= sleep_cmd_in;
            sleep_instr_out <= sleep_q;
            clear_watchdog_instr_out <= sleep_cmd_in | clear_cmd_in;
        end
    end
endmodule
`default_nettype wire

// ===== wd_sleep_ctrl_test.sv
/* Bench for the watchdog and sleep controller.
   Assumes the package, the config header and the CPU core model. */
`timescale 1ns/1ps
`default_nettype none
`include "wd_sleep_cfg.svh"
module wd_sleep_ctrl_test;
    import wd_sleep_pkg::*;
    logic clk = 0, rst = 1, wosc = 0, scmd = 0, ccmd = 0, global_irq_enable = 0, master_clear_pin_n = 1, fuse = 1;
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, xtal = 0;
    logic clr, slp, awr, wrdy, bv, arr, rv, dev_rst, osc_off, pref, res, vec, to_n, pd_n;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [3:0] ws = 0;
    logic [1:0] br, rr;
    logic [7:0] fl = 0, en = 0, pd = 0, po = 0, pd_o, po_o;
    int fail_count = 0, samples_checked = 0, n_rst = 0;
    always #4 clk = ~clk;
    always #20 wosc = ~wosc;
    always @(posedge clk) n_rst <= n_rst + (dev_rst === 1'b1);
    cpu_core_model cpu (.mclk_in(clk), .reset_in(rst), .sleep_cmd_in(scmd),
        .clear_cmd_in(ccmd), .clear_watchdog_instr_out(clr), .sleep_instr_out(slp));
    wd_sleep_ctrl #(.WAKE_CAPABLE(8'h7F), .BASE_TICKS(4), .OST_CYCLES(8)) dut (
        .mclk_in(clk), .reset_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_bresp_out(br),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
        .clear_watchdog_instr_in(clr), .sleep_instr_in(slp), .global_irq_enable_in(global_irq_enable),
        .irq_flags_in(fl), .irq_enables_in(en), .master_clear_pin_n_in(master_clear_pin_n),
        .watchdog_osc_in(wosc), .watchdog_enable_fuse_in(fuse), .crystal_mode_in(xtal),
        .port_drive_in(pd), .port_oe_in(po), .device_reset_out(dev_rst),
        .osc_driver_off_out(osc_off), .prefetch_next_out(pref), .resume_out(res),
        .vector_after_next_out(vec), .timeout_flag_n_out(to_n),
        .powerdown_flag_n_out(pd_n), .port_drive_out(pd_o), .port_oe_out(po_o));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_hi(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'b1; i++) @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] exp);
        @(posedge clk);
        {awa, wd, ws} <= {a, 24'h0, d, s};
        {awv, wv, bry} <= 3'b111;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        bry <= 1'b0;
        chk("bresp", exp, br);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] exp);
        @(posedge clk);
        ara <= a;
        {arv, rry} <= 2'b11;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rry <= 1'b0;
        chk("rresp", exp, rr);
        chk("rdata", {24'h0, d}, rdat);
    endtask
    task automatic go_sleep();
        @(posedge clk) scmd <= 1'b1;
        @(posedge clk) scmd <= 1'b0;
        wait_hi(pref, 10);
        chk("prefetch", 1, pref);
    endtask
    task automatic t_regs();
        rd(12'h00C, 8'h1A, `RESP_OKAY);
        rd(12'h204, `OPTION_RESET, `RESP_OKAY);
        rd(12'h100, 8'h00, `RESP_SLVERR);
        wr(12'h204, 8'h08, 4'h0, `RESP_OKAY);
        rd(12'h204, `OPTION_RESET, `RESP_OKAY);
    endtask
    task automatic t_sleep_irq();
        {pd, po} <= 16'hA50F;
        go_sleep();
        chk("sleep", 3'b101, {osc_off, pd_n, to_n});
        {pd, po, fl, en} <= 32'h5AF08180;
        repeat (4) @(posedge clk);
        chk("pins held", 16'hA50F, {pd_o, po_o});
        chk("no wake", 1, osc_off);
        en <= 8'h81;
        wait_hi(res, 20);
        chk("resume vec", 2'b10, {res, vec});
        @(posedge clk) {fl, en} <= 16'h0;
        chk("pins run", 16'h5AF0, {pd_o, po_o});
    endtask
    task automatic t_nop();
        @(posedge clk) {fl, en} <= 16'h0101;
        go_sleep();
        chk("nop", 2'b01, {osc_off, pd_n});
        {fl, en} <= 16'h0;
    endtask
    task automatic t_xtal();
        @(posedge clk) {xtal, global_irq_enable} <= 2'b11;
        go_sleep();
        {fl, en} <= 16'h0202;
        repeat (6) @(posedge clk);
        chk("startup wait", 0, res);
        wait_hi(res, 20);
        chk("xtal resume", 2'b11, {res, vec});
        {xtal, global_irq_enable, fl, en} <= 18'h0;
    endtask
    task automatic t_watchdog();
        int base;
        @(posedge clk) ccmd <= 1'b1;
        @(posedge clk) ccmd <= 1'b0;
        wr(12'h204, 8'h08, 4'h1, `RESP_OKAY);
        go_sleep();
        wait_hi(res, 60);
        chk("wd wake", 3'b100, {res, to_n, vec});
        chk("wd wake", 0, dev_rst);
        base = n_rst;
        repeat (10) begin
            @(posedge clk) ccmd <= 1'b1;
            @(posedge clk) ccmd <= 1'b0;
            repeat (8) @(posedge clk);
        end
        chk("cleared", base, n_rst);
        rd(12'h204, 8'h08, `RESP_OKAY);
        wait_hi(dev_rst, 60);
        chk("run expiry", 2'b10, {dev_rst, to_n});
    endtask
    task automatic t_master_clear_pin();
        go_sleep();
        master_clear_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("master_clear_pin wake", 3'b100, {dev_rst, res, osc_off});
        master_clear_pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("master_clear_pin flags", 3'b001, {dev_rst, pd_n, to_n});
    endtask
    task automatic t_fuse_off();
        int base;
        @(posedge clk) {rst, fuse} <= 2'b10;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(12'h00C, 8'h18, `RESP_OKAY);
        wr(12'h204, 8'h08, 4'h1, `RESP_OKAY);
        base = n_rst;
        repeat (60) @(posedge clk);
        chk("fuse off", base, n_rst);
        chk("fuse timeout", 1, to_n);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_nop();
        t_sleep_irq();
        t_xtal();
        t_watchdog();
        t_master_clear_pin();
        t_fuse_off();
        finish_test();
    end
endmodule
`default_nettype wire
